// File: inc/flrg_map.vh
// Constants for the FIFO level and transmit count register group.
// Assumes an 8-bit host register port with 5-bit register addresses.
`ifndef FLRG_MAP_VH
`define FLRG_MAP_VH
`define FLRG_ADDR_TEST        5'h1b
`define FLRG_ADDR_FILL        5'h1c
`define FLRG_ADDR_CNT_HI      5'h1d
`define FLRG_ADDR_CNT_LO      5'h1e
`define FLRG_RESET_BYTE       8'h00
`define FLRG_BIT_FAST_CLOCK   0
`define FLRG_BIT_DEC_TEST     1
`define FLRG_BIT_IO_TEST_LO   2
`define FLRG_BIT_IO_TEST_HI   3
`define FLRG_TEST_MODE_MASK   8'h0e
`define FLRG_BIT_OVERFLOW     7
`define FLRG_FIFO_DEPTH       8'h80
`define FLRG_CNT_ZERO         7'h00
`define FLRG_CNT_ONE          7'h01
`define FLRG_CNT_TOP          7'h7f
`endif

// File: rtl/flrg_fill_counter.v
// FIFO fill counter with sticky overflow flag.
// Assumes push and pop strobes come from logic on i_clock.
`timescale 1ns/1ps
`include "flrg_map.vh"
module flrg_fill_counter (
   input  wire       i_clock,
   input  wire       i_reset,
   input  wire       i_clear,
   input  wire       i_push,
   input  wire       i_pop,
   output reg  [6:0] o_count,
   output reg        o_full,
   output reg        o_overflow
);
   wire do_push = i_push & ~(o_full & ~i_pop);
   wire do_pop  = i_pop & (o_full | (o_count != `FLRG_CNT_ZERO));
   wire ovf_event = i_push & o_full & ~i_pop;
   always @(posedge i_clock) begin
      if (i_reset) begin
         o_count    <= `FLRG_CNT_ZERO;
         o_full     <= 1'b0;
         o_overflow <= 1'b0;
      end else if (i_clear) begin
         // A lost byte in the clear cycle still shows: set beats clear
         o_count    <= `FLRG_CNT_ZERO;
         o_full     <= 1'b0;
         o_overflow <= ovf_event;
      end else begin
         if (ovf_event)
            o_overflow <= 1'b1;
         if (do_push & ~do_pop) begin
            if (o_count == `FLRG_CNT_TOP)
               o_full <= 1'b1;
            o_count <= o_count + `FLRG_CNT_ONE;
         end else if (do_pop & ~do_push) begin
            if (o_full)
               o_full <= 1'b0;
            o_count <= o_count - `FLRG_CNT_ONE;
         end
      end
   end
endmodule // flrg_fill_counter

// File: rtl/flrg_regs.v
// Register group: coder test control, FIFO fill level, transmit count.
// Assumes host port decode upstream gives write/read strobes on i_clock;
// chip enable and stop condition arrive from pins and are synchronised here.
//
// How it works
// - Test control register clears on reset or chip enable low.
// - Writing decoder or I/O test bits enters test mode.
// - Test mode holds until host stop; then those bits self-clear.
// - Fast clock bit runs coders straight from the carrier clock.
// - Overflow flag bit 7 sets when more than 128 bytes offered.
// - Low seven bits report bytes waiting in the FIFO; a full FIFO of 128 reads 0.
// - Upper count register clears on reset or chip enable low.
// - Both count registers clear when transmit frame end is sent.
// - Lower bit 0 flags broken byte; bits 3..1 give its bit count.
`timescale 1ns/1ps
`include "flrg_map.vh"
module flrg_regs (
   input  wire        i_clock,
   input  wire        i_reset,
   input  wire        i_chip_enable,
   input  wire        i_host_stop,
   input  wire        i_write,
   input  wire        i_read,
   input  wire [4:0]  i_address,
   input  wire [7:0]  i_write_data,
   input  wire        i_fifo_push,
   input  wire        i_fifo_pop,
   input  wire        i_fifo_clear,
   input  wire        i_tx_frame_end,
   output reg  [7:0]  o_read_data,
   output reg         o_test_mode,
   output reg         o_coder_fast_clock,
   output reg  [11:0] o_tx_byte_count,
   output reg         o_broken_byte_flag,
   output reg  [2:0]  o_partial_bits_count,
   output reg         o_fifo_overflow
);
   ////////////////////////////////////////////////////////////////////
   reg        enable_meta;
   reg        enable_sync;
   reg        stop_meta;
   reg        stop_sync;
   reg        stop_prev;
   reg  [7:0] coder_test_control;
   reg  [7:0] transmit_count_upper;
   reg  [7:0] transmit_count_lower;
   wire [6:0] fill_count;
   wire       fill_full;
   wire       overflow;
   wire       stop_rise = stop_sync & ~stop_prev;
   wire       held_off  = i_reset | ~enable_sync;
   wire       wr_test   = i_write & (i_address == `FLRG_ADDR_TEST);
   wire       wr_hi     = i_write & (i_address == `FLRG_ADDR_CNT_HI);
   wire       wr_lo     = i_write & (i_address == `FLRG_ADDR_CNT_LO);
   wire [6:0] fill_shown = fill_full ? `FLRG_CNT_ZERO : fill_count;

   // Pins pass two flops; stop is edge-detected after the second
   always @(posedge i_clock) begin
      if (i_reset) begin
         enable_meta <= 1'b0;
         enable_sync <= 1'b0;
         stop_meta   <= 1'b0;
         stop_sync   <= 1'b0;
         stop_prev   <= 1'b0;
      end else begin
         enable_meta <= i_chip_enable;
         enable_sync <= enable_meta;
         stop_meta   <= i_host_stop;
         stop_sync   <= stop_meta;
         stop_prev   <= stop_sync;
      end
   end

   ////////////////////////////////////////////////////////////////////
   always @(posedge i_clock) begin
      if (held_off) begin
         coder_test_control <= `FLRG_RESET_BYTE;
      end else if (wr_test) begin
         coder_test_control <= i_write_data;
      end else if (stop_rise) begin
         coder_test_control <= coder_test_control & ~`FLRG_TEST_MODE_MASK;
      end
   end

   // Frame end beats a host write in the same cycle
   always @(posedge i_clock) begin
      if (held_off | i_tx_frame_end) begin
         transmit_count_upper <= `FLRG_RESET_BYTE;
         transmit_count_lower <= `FLRG_RESET_BYTE;
      end else begin
         if (wr_hi)
            transmit_count_upper <= i_write_data;
         if (wr_lo)
            transmit_count_lower <= i_write_data;
      end
   end

   ////////////////////////////////////////////////////////////////////
   flrg_fill_counter u_fill (
      .i_clock    (i_clock),
      .i_reset    (held_off),
      .i_clear    (i_fifo_clear),
      .i_push     (i_fifo_push),
      .i_pop      (i_fifo_pop),
      .o_count    (fill_count),
      .o_full     (fill_full),
      .o_overflow (overflow)
   );

   // Outputs registered; read data mux one cycle after i_read
   always @(posedge i_clock) begin
      if (i_reset) begin
         o_read_data          <= `FLRG_RESET_BYTE;
         o_test_mode          <= 1'b0;
         o_coder_fast_clock   <= 1'b0;
         o_tx_byte_count      <= 12'h000;
         o_broken_byte_flag   <= 1'b0;
         o_partial_bits_count <= 3'h0;
         o_fifo_overflow      <= 1'b0;
      end else begin
         o_test_mode <= |(coder_test_control & `FLRG_TEST_MODE_MASK);
         o_coder_fast_clock   <= coder_test_control[`FLRG_BIT_FAST_CLOCK];
         o_tx_byte_count      <= {transmit_count_upper, transmit_count_lower[7:4]};
         o_broken_byte_flag   <= transmit_count_lower[0];
         o_partial_bits_count <= transmit_count_lower[0] ?
                                 transmit_count_lower[3:1] : 3'h0;
         o_fifo_overflow      <= overflow;
         if (i_read) begin
            case (i_address)
               `FLRG_ADDR_TEST:   o_read_data <= coder_test_control;
               `FLRG_ADDR_FILL:   o_read_data <= {overflow, fill_shown};
               `FLRG_ADDR_CNT_HI: o_read_data <= transmit_count_upper;
               `FLRG_ADDR_CNT_LO: o_read_data <= transmit_count_lower;
               default:           o_read_data <= `FLRG_RESET_BYTE;
            endcase
         end
      end
   end
endmodule // flrg_regs

// File: sim/flrg_chk_sva.sv
// Register group checker.
// Bound to flrg_regs; single clock.
`timescale 1ns/1ps
module flrg_chk(input wire i_clock,i_reset,i_chip_enable,i_host_stop,i_write,
 input wire [4:0] i_address,input wire [7:0] i_write_data,input wire i_fifo_clear,
 input wire i_tx_frame_end,o_test_mode,o_coder_fast_clock,o_fifo_overflow,
 input wire [11:0] o_tx_byte_count);
default clocking @(posedge i_clock); endclocking
default disable iff (i_reset);
sequence wr(a); i_chip_enable[*4] ##0 i_write && i_address==a; endsequence
rst_clr_a: assert property(disable iff(1'b0) i_reset |=> !o_test_mode) else $error("rst");
test_on_a: assert property(wr(5'h1b) |-> ##2 o_test_mode==(|$past(i_write_data[3:1],2)))
 else $error("test");
fast_clk_a: assert property(wr(5'h1b) |-> ##2 o_coder_fast_clock==$past(i_write_data[0],2))
 else $error("clk");
stop_exit_a: assert property($rose(i_host_stop) |-> ##[1:6] !o_test_mode)
 else $error("stop");
cnt_map_a: assert property(wr(5'h1d) ##0 !i_tx_frame_end |-> ##2
 o_tx_byte_count[11:4]==$past(i_write_data,2)) else $error("count");
frame_clr_a: assert property(i_tx_frame_end |-> ##2 !o_tx_byte_count) else $error("tx");
en_clr_a: assert property(!i_chip_enable[*5] |-> !o_test_mode && !o_tx_byte_count)
 else $error("en");
ovf_hold_a: assert property(o_fifo_overflow && !i_fifo_clear && !$past(i_fifo_clear)
 |=> o_fifo_overflow) else $error("ovf");
cover property(o_fifo_overflow);
cover property(o_test_mode ##1 !o_test_mode);
cover property(i_tx_frame_end);
endmodule // flrg_chk
bind flrg_regs flrg_chk C(.*);

// File: sim/flrg_host.sv
// Host port model.
// One-cycle strobes; released data bus shows junk.
`timescale 1ns/1ps
module flrg_host(input wire i_clock,output reg o_write=0,o_read=0,
 output reg [4:0] o_address=0,output reg [7:0] o_write_data=0);
task acc(input w,input [4:0] a,input [7:0] d);
 @(posedge i_clock) #1 {o_write,o_read,o_address,o_write_data}={w,!w,a,d};
 @(posedge i_clock) #1 {o_write,o_read,o_write_data}={2'b00,~d};
endtask
endmodule // flrg_host

// File: sim/flrg_regs_test.sv
// Bench top: host model, scoreboard.
// Checker bound in its own file.
`timescale 1ns/1ps
module flrg_regs_test;
reg i_clock=0,i_reset=1,i_chip_enable=1,i_host_stop=0,i_fifo_push=0,i_fifo_pop=0,
 i_fifo_clear=0,i_tx_frame_end=0;
wire i_write,i_read,o_test_mode,o_coder_fast_clock,o_broken_byte_flag,o_fifo_overflow;
wire [4:0] i_address;
wire [7:0] i_write_data,o_read_data;
wire [11:0] o_tx_byte_count;
wire [2:0] o_partial_bits_count;
reg [31:0] s=32'hdb698a68;
reg [7:0] v,u;
integer errors=0,check_count=0,i,x,n;
flrg_host H(.i_clock,.o_write(i_write),.o_read(i_read),.o_address(i_address),
 .o_write_data(i_write_data));
flrg_regs DUT(.*);
initial forever #2 i_clock=~i_clock;
function [7:0] rnd(); s^=s<<13; s^=s>>17; s^=s<<5; rnd=s[7:0]; endfunction
task chk(input [15:0] g,e); check_count++;
 if(g!==e) begin errors++; $display("[ERR] %0t mismatch",$time); end endtask
task rd(input [4:0] a,input [7:0] e); H.acc(1'b0,a,8'h00); chk(o_read_data,e); endtask
task results; $display("errors %0d checks %0d",errors,check_count);
 if(errors==0&&check_count>0) $display("ALL TESTS PASSED"); else $display("TESTS FAILED");
 $finish; endtask
initial #40000 begin errors++; results; end
initial begin
 #15 i_reset=0;
 for(i=27;i<32;i++) rd(i[4:0],8'h00);
 for(i=0;i<4;i++) begin
  v=rnd()&(i?8'hff:8'hf1); H.acc(1,5'h1b,v); #8;
  chk({o_test_mode,o_coder_fast_clock},{|v[3:1],v[0]});
  i_host_stop=1; #24 i_host_stop=0;
  rd(5'h1b,v&8'hf1);
  v=rnd(); u=rnd(); H.acc(1,5'h1d,v); H.acc(1,5'h1e,u); #8;
  chk(o_tx_byte_count,{v,u[7:4]});
  rd(5'h1d,v);
  rd(5'h1e,u);
  chk({o_broken_byte_flag,o_partial_bits_count},u[0]?{1'b1,u[3:1]}:0);
  i_tx_frame_end=1; #4 i_tx_frame_end=0; #8;
  chk({o_tx_byte_count,o_broken_byte_flag},0);
  x=124+i*3+rnd()%3; n=x>128?128:x;
  i_fifo_push=1; #(4*x) i_fifo_push=0;
  rd(5'h1c,{x>128,n[6:0]});
  i_fifo_pop=1; #4 i_fifo_pop=0; n--;
  rd(5'h1c,{x>128,n[6:0]});
  i_fifo_clear=1; #4 i_fifo_clear=0;
 end
 H.acc(1,5'h1b,8'h0f); H.acc(1,5'h1d,8'h5a); i_chip_enable=0; #20;
 chk({o_test_mode,o_coder_fast_clock,o_tx_byte_count},0);
 results;
end
endmodule // flrg_regs_test
